// [include/imu_dvel_gyro_regs.vh]
`ifndef IMU_DVEL_GYRO_REGS_VH
`define IMU_DVEL_GYRO_REGS_VH

// Byte addresses of the even byte of each 16-bit register.
`define Y_DELTA_VELOCITY_LOW_ADDR 7'h34
`define Y_DELTA_VELOCITY_HIGH_ADDR 7'h36
`define Z_DELTA_VELOCITY_LOW_ADDR 7'h38
`define Z_DELTA_VELOCITY_HIGH_ADDR 7'h3A
`define X_RATE_OFFSET_LOW_ADDR 7'h40
`define X_RATE_OFFSET_HIGH_ADDR 7'h42
`define Y_RATE_OFFSET_LOW_ADDR 7'h44
`define Y_RATE_OFFSET_HIGH_ADDR 7'h46
`define Z_RATE_OFFSET_LOW_ADDR 7'h48
`define Z_RATE_OFFSET_HIGH_ADDR 7'h4A

// Reset values of the writable bias words.
`define RATE_OFFSET_RESET 16'h0000

// Value read back for an address this bank does not own.
`define UNMAPPED_READ 16'h0000

// Delta velocity format: full scale in m/sec and the zero code.
`define DVEL_FULL_SCALE_MPS 400
`define DVEL_ZERO 32'h00000000
`define DVEL_POS_LIMIT 32'h7FFFFFFF
`define DVEL_NEG_LIMIT 32'h80000000

// Sample rate and clock rate, and the cycle count between samples.
`define REF_CLK_HZ 20000000
`define SAMPLE_RATE_HZ 2000
`define SAMPLE_PERIOD_CYCLES (`REF_CLK_HZ / `SAMPLE_RATE_HZ)

`endif

// [hw/dvel_integrator.v]
`timescale 1ns/1ns
`include "imu_dvel_gyro_regs.vh"

// Trapezoidal integrator of one acceleration axis over one decimation period.
module dvel_integrator #(
	parameter ACC_WIDTH = 16,
	parameter SUM_WIDTH = 40,
	parameter SCALE_SHIFT = 0
)(
	input wire ref_clk,
	input wire reset,
	input wire sampleEn,
	input wire [ACC_WIDTH-1:0] accSample,
	input wire [15:0] decimationSetting,
	output reg [31:0] result_ff,
	output reg resultValid_ff
);

	// Clamps a wide signed sum into the 32-bit output code range.
	function [31:0] sat32;
		input [SUM_WIDTH-1:0] val;
		begin
			if (!val[SUM_WIDTH-1] && (|val[SUM_WIDTH-2:31]))
				sat32 = `DVEL_POS_LIMIT;
			else if (val[SUM_WIDTH-1] && !(&val[SUM_WIDTH-2:31]))
				sat32 = `DVEL_NEG_LIMIT;
			else
				sat32 = val[31:0];
		end
	endfunction

	reg [ACC_WIDTH-1:0] prevAcc_ff; // Previous acceleration sample.
	reg [SUM_WIDTH-1:0] accum_ff; // Running trapezoid sum of the period.
	reg [15:0] count_ff; // Samples taken so far in this period.
	wire [SUM_WIDTH-1:0] pairSum; // Current plus previous sample, sign extended.
	wire [SUM_WIDTH-1:0] total; // Sum including the current pair.
	wire [SUM_WIDTH-1:0] scaled; // Total after the fixed output scaling.

	assign pairSum = {{(SUM_WIDTH-ACC_WIDTH){accSample[ACC_WIDTH-1]}}, accSample}
		+ {{(SUM_WIDTH-ACC_WIDTH){prevAcc_ff[ACC_WIDTH-1]}}, prevAcc_ff};
	assign total = accum_ff + pairSum;
	assign scaled = total <<< SCALE_SHIFT;

	// Sums pairs for decimationSetting plus one samples, then publishes and restarts.
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			prevAcc_ff <= {ACC_WIDTH{1'b0}};
			accum_ff <= {SUM_WIDTH{1'b0}};
			count_ff <= 16'h0000;
			result_ff <= `DVEL_ZERO;
			resultValid_ff <= 1'b0;
		end
		else
		begin
			resultValid_ff <= 1'b0;
			if (sampleEn)
			begin
				prevAcc_ff <= accSample;
				if (count_ff == decimationSetting)
				begin
					// Period complete: saturated result, both halves at once.
					result_ff <= sat32(scaled);
					resultValid_ff <= 1'b1;
					accum_ff <= {SUM_WIDTH{1'b0}};
					count_ff <= 16'h0000;
				end
				else
				begin
					// Still inside the period: keep summing.
					accum_ff <= total;
					count_ff <= count_ff + 16'h0001;
				end
			end
		end
	end

endmodule // dvel_integrator

// [hw/imu_dvel_out_gyro_bias_regs.v]
`timescale 1ns/1ns
`include "imu_dvel_gyro_regs.vh"

module imu_dvel_out_gyro_bias_regs #(
	parameter SAMPLE_PERIOD = `SAMPLE_PERIOD_CYCLES,
	parameter ACC_WIDTH = 16,
	parameter DVEL_SCALE_SHIFT = 0
)(
	input wire ref_clk,
	input wire reset,
	// Host register port: byte address, strobes and data.
	input wire [6:0] regAddr,
	input wire regWrEn,
	input wire [15:0] regWrData,
	input wire regRdEn,
	output reg [15:0] regRdData_ff,
	output reg regRdValid_ff,
	// Flash keeper: restore pulse, stored image and live image.
	input wire flashRestore,
	input wire [95:0] flashImage,
	output wire [95:0] biasImage,
	// Sample inputs from the sensor front end.
	input wire [15:0] decimationSetting,
	input wire [ACC_WIDTH-1:0] accelY,
	input wire [ACC_WIDTH-1:0] accelZ,
	input wire [31:0] factoryGyroX,
	input wire [31:0] factoryGyroY,
	input wire [31:0] factoryGyroZ,
	// Processing outputs towards the rest of the unit.
	output reg sampleTick_ff,
	output reg [31:0] gyroX_ff,
	output reg [31:0] gyroY_ff,
	output reg [31:0] gyroZ_ff,
	output reg gyroValid_ff,
	output reg dvelUpdate_ff
);

	// The bank has three parts. A divider makes the 2000 Hz processing tick.
	// The rate chain adds the host's 32-bit offset to each factory-corrected
	// rate sample on that tick. Two integrators sum acceleration over one
	// decimation period, and the results are published here as velocity words.
	// The host reaches the six offset words and the four velocity words
	// through a plain strobe port; everything else reads as zero.
	// The flash keeper outside saves biasImage and restores it on request.

	// Adds a signed 32-bit offset to a signed 32-bit sample and clamps the result.
	// It serves all three axes, so the clipping is the same everywhere.
	function [31:0] addSat;
		input [31:0] sample;
		input [31:0] offset;
		reg [32:0] wide;
		begin
			wide = {sample[31], sample} + {offset[31], offset};
			// The two top bits differ only when the true sum left the 32-bit range.
			// The extra sign bit then tells which limit was crossed.
			if (wide[32] != wide[31])
				addSat = wide[32] ? `DVEL_NEG_LIMIT : `DVEL_POS_LIMIT;
			else
				addSat = wide[31:0];
		end
	endfunction

	// Tells whether a byte address falls on the 16-bit register at a given base.
	function hitWord;
		input [6:0] addr;
		input [6:0] base;
		begin
			// Bit 0 picks the byte within the word, so the odd address hits as well.
			hitWord = (addr[6:1] == base[6:1]);
		end
	endfunction

	// Width of the sample divider counter.
	// It is wide enough for the default 10000-cycle period and far beyond.
	localparam DIV_WIDTH = 24;
	// Last count of the divider as a full word, before it is cut to the counter width.
	localparam [31:0] DIV_LAST_WORD = SAMPLE_PERIOD - 1;
	// Last count of the divider, sized to the counter.
	localparam [DIV_WIDTH-1:0] DIV_LAST = DIV_LAST_WORD[DIV_WIDTH-1:0];

	// Sample divider state.
	reg [DIV_WIDTH-1:0] divCount_ff; // Cycles since the last sample tick.
	wire [DIV_WIDTH-1:0] nxt_divCount; // Next divider count.

	// Writable offset words, all reset to zero and kept in flash.
	reg [15:0] xOffLow_ff; // X rate offset, lower word.
	reg [15:0] xOffHigh_ff; // X rate offset, upper word.
	reg [15:0] yOffLow_ff; // Y rate offset, lower word.
	reg [15:0] yOffHigh_ff; // Y rate offset, upper word.
	reg [15:0] zOffLow_ff; // Z rate offset, lower word.
	reg [15:0] zOffHigh_ff; // Z rate offset, upper word.

	// Combined offsets as seen by the rate chain.
	wire [31:0] xOffset; // X offset as one 32-bit value.
	wire [31:0] yOffset; // Y offset as one 32-bit value.
	wire [31:0] zOffset; // Z offset as one 32-bit value.

	// Velocity path: raw integrator results and the published copies.
	wire [31:0] dvelYRaw; // Y integrator result.
	wire [31:0] dvelZRaw; // Z integrator result.
	wire dvelYDone; // Y integrator finished a period.
	wire dvelZDone; // Z integrator finished a period.
	reg [31:0] dvelY_ff; // Published Y delta velocity.
	reg [31:0] dvelZ_ff; // Published Z delta velocity.

	// Read path.
	reg [15:0] nxt_regRdData; // Read data chosen by the address.

	// Divider: one tick every SAMPLE_PERIOD cycles of ref_clk.
	// It wraps to zero after the last count instead of running on.
	assign nxt_divCount = (divCount_ff == DIV_LAST) ? {DIV_WIDTH{1'b0}}
		: divCount_ff + {{(DIV_WIDTH-1){1'b0}}, 1'b1};

	// Produces the 2000 Hz processing enable for the whole chain.
	// The tick is registered, so every consumer sees it on the same edge.
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// The count restarts at zero; the first tick comes SAMPLE_PERIOD cycles on.
			divCount_ff <= {DIV_WIDTH{1'b0}};
			sampleTick_ff <= 1'b0;
		end
		else
		begin
			divCount_ff <= nxt_divCount;
			sampleTick_ff <= (divCount_ff == DIV_LAST);
		end
	end

	// The offset pairs join upper over lower into one signed 32-bit value.
	assign xOffset = {xOffHigh_ff, xOffLow_ff};
	assign yOffset = {yOffHigh_ff, yOffLow_ff};
	assign zOffset = {zOffHigh_ff, zOffLow_ff};

	// The saved image is what the flash keeper writes back on a save.
	// It comes back later on flashImage, in the same order.
	assign biasImage = {zOffHigh_ff, zOffLow_ff, yOffHigh_ff, yOffLow_ff, xOffHigh_ff, xOffLow_ff};

	// Writable offset words: reset to zero, loaded from flash, or written by the host.
	// Each word is written on its own; the pair is only joined downstream.
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// All six words come out of reset as zero.
			xOffLow_ff <= `RATE_OFFSET_RESET;
			xOffHigh_ff <= `RATE_OFFSET_RESET;
			yOffLow_ff <= `RATE_OFFSET_RESET;
			yOffHigh_ff <= `RATE_OFFSET_RESET;
			zOffLow_ff <= `RATE_OFFSET_RESET;
			zOffHigh_ff <= `RATE_OFFSET_RESET;
		end
		else if (flashRestore)
		begin
			// A restore from flash takes the whole stored image at once.
			// A host write in the same cycle is lost; the restore wins.
			// X axis words.
			xOffLow_ff <= flashImage[15:0];
			xOffHigh_ff <= flashImage[31:16];
			// Y axis words.
			yOffLow_ff <= flashImage[47:32];
			yOffHigh_ff <= flashImage[63:48];
			// Z axis words.
			zOffLow_ff <= flashImage[79:64];
			zOffHigh_ff <= flashImage[95:80];
		end
		else if (regWrEn)
		begin
			// A host write lands in the one word it addresses.
			// Velocity words and unmapped addresses are ignored.
			// X axis words.
			if (hitWord(regAddr, `X_RATE_OFFSET_LOW_ADDR))
				xOffLow_ff <= regWrData;
			if (hitWord(regAddr, `X_RATE_OFFSET_HIGH_ADDR))
				xOffHigh_ff <= regWrData;
			// Y axis words.
			if (hitWord(regAddr, `Y_RATE_OFFSET_LOW_ADDR))
				yOffLow_ff <= regWrData;
			if (hitWord(regAddr, `Y_RATE_OFFSET_HIGH_ADDR))
				yOffHigh_ff <= regWrData;
			// Z axis words.
			if (hitWord(regAddr, `Z_RATE_OFFSET_LOW_ADDR))
				zOffLow_ff <= regWrData;
			if (hitWord(regAddr, `Z_RATE_OFFSET_HIGH_ADDR))
				zOffHigh_ff <= regWrData;
		end
	end

	// Rate chain: the user offset is applied right after the factory stage.
	// Nothing sits between the factory stage and this add.
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// No corrected sample exists before the first tick.
			gyroX_ff <= 32'h00000000;
			gyroY_ff <= 32'h00000000;
			gyroZ_ff <= 32'h00000000;
			gyroValid_ff <= 1'b0;
		end
		else
		begin
			// The valid pulse follows the tick by exactly one cycle.
			gyroValid_ff <= sampleTick_ff;
			// Between ticks the outputs hold the last corrected sample.
			if (sampleTick_ff)
			begin
				// Each axis gets its own offset, in the same manner.
				// Clipping instead of wrapping stops a large offset from
				// flipping a near full-scale rate to the opposite sign.
				gyroX_ff <= addSat(factoryGyroX, xOffset);
				gyroY_ff <= addSat(factoryGyroY, yOffset);
				gyroZ_ff <= addSat(factoryGyroZ, zOffset);
			end
		end
	end

	// Y axis velocity integrator over one decimation period.
	// Both integrators share the tick and the setting, so they finish on the same edge.
	dvel_integrator #(
		.ACC_WIDTH(ACC_WIDTH),
		.SUM_WIDTH(40),
		.SCALE_SHIFT(DVEL_SCALE_SHIFT)
	) yIntegrator (
		.ref_clk(ref_clk),
		.reset(reset),
		.sampleEn(sampleTick_ff),
		.accSample(accelY),
		.decimationSetting(decimationSetting),
		.result_ff(dvelYRaw),
		.resultValid_ff(dvelYDone)
	);

	// Z axis velocity integrator over one decimation period.
	// It mirrors the Y integrator on the Z acceleration input.
	dvel_integrator #(
		.ACC_WIDTH(ACC_WIDTH),
		.SUM_WIDTH(40),
		.SCALE_SHIFT(DVEL_SCALE_SHIFT)
	) zIntegrator (
		.ref_clk(ref_clk),
		.reset(reset),
		.sampleEn(sampleTick_ff),
		.accSample(accelZ),
		.decimationSetting(decimationSetting),
		.result_ff(dvelZRaw),
		.resultValid_ff(dvelZDone)
	);

	// Publishes both axes together so that a read never mixes two periods.
	// The copies let a slow host read both halves of one period while the next is summed.
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// Velocity reads zero until the first period has been summed.
			dvelY_ff <= `DVEL_ZERO;
			dvelZ_ff <= `DVEL_ZERO;
			dvelUpdate_ff <= 1'b0;
		end
		else
		begin
			// Both axes must be done; they always finish on the same edge.
			dvelUpdate_ff <= dvelYDone & dvelZDone;
			if (dvelYDone & dvelZDone)
			begin
				// Both 32-bit words change in one edge, the halves stay paired.
				dvelY_ff <= dvelYRaw;
				dvelZ_ff <= dvelZRaw;
			end
		end
	end

	// Read decode: only the velocity and offset words are visible here.
	always @*
	begin
		// Any other address reads as zero, so nothing hidden leaks out.
		nxt_regRdData = `UNMAPPED_READ;
		// Y velocity words, read only.
		if (hitWord(regAddr, `Y_DELTA_VELOCITY_LOW_ADDR))
			nxt_regRdData = dvelY_ff[15:0];
		else if (hitWord(regAddr, `Y_DELTA_VELOCITY_HIGH_ADDR))
			nxt_regRdData = dvelY_ff[31:16];
		// Z velocity words, read only.
		else if (hitWord(regAddr, `Z_DELTA_VELOCITY_LOW_ADDR))
			nxt_regRdData = dvelZ_ff[15:0];
		else if (hitWord(regAddr, `Z_DELTA_VELOCITY_HIGH_ADDR))
			nxt_regRdData = dvelZ_ff[31:16];
		// X offset words read back what was written or restored.
		else if (hitWord(regAddr, `X_RATE_OFFSET_LOW_ADDR))
			nxt_regRdData = xOffLow_ff;
		else if (hitWord(regAddr, `X_RATE_OFFSET_HIGH_ADDR))
			nxt_regRdData = xOffHigh_ff;
		// Y offset words.
		else if (hitWord(regAddr, `Y_RATE_OFFSET_LOW_ADDR))
			nxt_regRdData = yOffLow_ff;
		else if (hitWord(regAddr, `Y_RATE_OFFSET_HIGH_ADDR))
			nxt_regRdData = yOffHigh_ff;
		// Z offset words.
		else if (hitWord(regAddr, `Z_RATE_OFFSET_LOW_ADDR))
			nxt_regRdData = zOffLow_ff;
		else if (hitWord(regAddr, `Z_RATE_OFFSET_HIGH_ADDR))
			nxt_regRdData = zOffHigh_ff;
	end

	// Read port: data is registered one cycle after the read strobe.
	// The decode uses the address held in the same cycle as the strobe.
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// No read is pending after reset.
			regRdData_ff <= 16'h0000;
			regRdValid_ff <= 1'b0;
		end
		else
		begin
			regRdValid_ff <= regRdEn;
			// The data register keeps the last read value between reads.
			if (regRdEn)
				regRdData_ff <= nxt_regRdData;
		end
	end

endmodule // imu_dvel_out_gyro_bias_regs

// [tb/imu_bank_checker_sva.sv]
`timescale 1ns/1ns
// Watches the register port and the sample path of the bias and velocity bank.
module imu_bank_checker #(
	parameter SAMPLE_PERIOD = 8
)(
	input wire ref_clk,
	input wire reset,
	input wire regWrEn,
	input wire regRdEn,
	input wire [15:0] regRdData_ff,
	input wire regRdValid_ff,
	input wire flashRestore,
	input wire [95:0] biasImage,
	input wire [31:0] factoryGyroX,
	input wire sampleTick_ff,
	input wire [31:0] gyroX_ff,
	input wire gyroValid_ff,
	input wire dvelUpdate_ff
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Saturating signed add; the rate output clips instead of wrapping.
	function automatic logic [31:0] satAdd(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = {a[31], a} + {b[31], b};
		if (s[32] != s[31])
			satAdd = s[32] ? 32'h80000000 : 32'h7FFFFFFF;
		else
			satAdd = s[31:0];
	endfunction

	// The bench runs the divider with a period of 8, so a tick is followed by 7 quiet cycles.
	sequence quietGap;
		!sampleTick_ff [*7];
	endsequence
	sequence rateAnswer;
		gyroValid_ff ##1 dvelUpdate_ff;
	endsequence

	a_rd_valid_follows: assert property (regRdEn |=> regRdValid_ff) else $error("read strobe not answered");
	a_rd_valid_caused: assert property (!regRdEn |=> !regRdValid_ff) else $error("read valid without strobe");
	a_rd_data_holds: assert property (!regRdValid_ff |-> $stable(regRdData_ff)) else $error("read data moved");
	a_tick_spacing: assert property (sampleTick_ff |=> quietGap ##1 sampleTick_ff) else $error("sample tick spacing");
	a_gyro_follows_tick: assert property (sampleTick_ff |=> gyroValid_ff) else $error("rate sample missing");
	a_gyro_valid_cause: assert property (gyroValid_ff |-> $past(sampleTick_ff)) else $error("rate valid without tick");
	a_gyro_offset_sum: assert property (gyroValid_ff |-> gyroX_ff == satAdd($past(factoryGyroX), $past(biasImage[31:0])))
		else $error("rate output is not sample plus offset");
	a_dvel_one_pulse: assert property (dvelUpdate_ff |=> !dvelUpdate_ff) else $error("velocity update too long");
	a_dvel_after_rate: assert property (dvelUpdate_ff |-> $past(gyroValid_ff)) else $error("velocity update off tick");
	a_bias_change_cause: assert property ($changed(biasImage) |-> $past(regWrEn || flashRestore))
		else $error("offset changed without write");
	c_rate_update: cover property (sampleTick_ff ##1 rateAnswer);
endmodule // imu_bank_checker

// [tb/reg_host_model.sv]
`timescale 1ns/1ns
// Host side of the register port: one strobe per access, held across the sampling edge.
module reg_host_model (
	input wire ref_clk,
	output logic [6:0] regAddr,
	output logic regWrEn,
	output logic [15:0] regWrData,
	output logic regRdEn,
	input wire [15:0] regRdData_ff,
	input wire regRdValid_ff
);
	initial
	begin
		regAddr = 7'h00;
		regWrEn = 1'b0;
		regWrData = 16'h0000;
		regRdEn = 1'b0;
	end

	// One write cycle; the strobe drops just after the edge that takes it.
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge ref_clk);
		#1;
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask

	// One read cycle; a missing valid returns a marker that no check expects.
	// The bench reads both halves right after an update so they come from one sample.
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge ref_clk);
		#1;
		regRdEn = 1'b0;
		d = (regRdValid_ff === 1'b1) ? regRdData_ff : 16'hDEAD;
	endtask
endmodule // reg_host_model

// [tb/imu_dvel_out_gyro_bias_regs_tb.sv]
`timescale 1ns/1ns
module imu_dvel_out_gyro_bias_regs_tb;
	logic ref_clk, reset, regWrEn, regRdEn, regRdValid_ff, flashRestore, sampleTick_ff, gyroValid_ff, dvelUpdate_ff;
	logic [6:0] regAddr;
	logic [15:0] regWrData, regRdData_ff, decimationSetting, accelY, accelZ, rv;
	logic [95:0] flashImage, biasImage;
	logic [31:0] factoryGyroX, factoryGyroY, factoryGyroZ, gyroX_ff, gyroY_ff, gyroZ_ff;
	int err_total, n_checks;
	logic [15:0] tbl [6] = '{16'h0010, 16'h0000, 16'hFFFE, 16'hFFFF, 16'h0100, 16'h0000};

	imu_dvel_out_gyro_bias_regs #(.SAMPLE_PERIOD(8)) u_dut (.ref_clk, .reset, .regAddr, .regWrEn, .regWrData,
		.regRdEn, .regRdData_ff, .regRdValid_ff, .flashRestore, .flashImage, .biasImage, .decimationSetting,
		.accelY, .accelZ, .factoryGyroX, .factoryGyroY, .factoryGyroZ, .sampleTick_ff, .gyroX_ff, .gyroY_ff,
		.gyroZ_ff, .gyroValid_ff, .dvelUpdate_ff);
	reg_host_model u_host (.ref_clk, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData_ff, .regRdValid_ff);

	// Free-running 50 ns clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk16(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t word %h expected %h", $time, g, e);
		end
	endtask

	task chk32(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask

	// Bounded wait for a rate sample (0) or a velocity update (1).
	task waitFor(input int sel);
		for (int i = 0; i < 400; i++)
		begin
			@(posedge ref_clk);
			#1;
			if ((sel == 0 && gyroValid_ff === 1'b1) || (sel == 1 && dvelUpdate_ff === 1'b1))
				return;
		end
		err_total++;
		$display("[FAIL] %0t wait ran out", $time);
		conclude();
	endtask

	// Reset values of all six offset words, via even and odd byte address.
	task t_reset();
		for (int i = 0; i < 6; i++)
		begin
			u_host.rd(7'h40 + 7'(2 * i + i % 2), rv);
			chk16(rv, 16'h0000);
		end
	endtask

	// Offsets, read-only and unmapped places, then the corrected rate with clipping on z.
	task t_rate();
		for (int i = 0; i < 6; i++)
			u_host.wr(7'h40 + 7'(2 * i), tbl[i]);
		for (int i = 0; i < 6; i++)
		begin
			u_host.rd(7'h41 + 7'(2 * i), rv);
			chk16(rv, tbl[i]);
		end
		for (int i = 0; i < 3; i++)
			chk32(biasImage[32 * i +: 32], {tbl[2 * i + 1], tbl[2 * i]});
		u_host.wr(7'h36, 16'h1234);
		u_host.rd(7'h36, rv);
		chk16(rv, 16'h0000);
		u_host.rd(7'h60, rv);
		chk16(rv, 16'h0000);
		factoryGyroX = 32'h00000064;
		factoryGyroY = 32'hFFFFFFCE;
		factoryGyroZ = 32'h7FFFFFF0;
		waitFor(0);
		waitFor(0);
		chk32(gyroX_ff, 32'h00000074);
		chk32(gyroY_ff, 32'hFFFFFFCC);
		chk32(gyroZ_ff, 32'h7FFFFFFF);
	endtask

	// A restore pulse in the same cycle as a host write wins.
	task t_flash();
		flashImage = 96'h0006_0005_0004_0003_0002_0001;
		fork
			u_host.wr(7'h40, 16'h7777);
			begin
				@(posedge ref_clk);
				#1;
				flashRestore = 1'b1;
				@(posedge ref_clk);
				#1;
				flashRestore = 1'b0;
			end
		join
		u_host.rd(7'h40, rv);
		chk16(rv, 16'h0001);
		chk32(biasImage[95:64], 32'h00060005);
	endtask

	// Steady acceleration: every period sums D+1 pairs, so the result is 2*(D+1)*a.
	task t_dvel(input logic [15:0] dec, input logic [15:0] ay, input logic [15:0] az);
		logic [31:0] ey, ez;
		ey = 32'($signed(ay)) * 2 * (32'(dec) + 1);
		ez = 32'($signed(az)) * 2 * (32'(dec) + 1);
		decimationSetting = dec;
		accelY = ay;
		accelZ = az;
		for (int i = 0; i < 3; i++)
			waitFor(1);
		u_host.rd(7'h36, rv);
		chk16(rv, ey[31:16]);
		u_host.rd(7'h34, rv);
		chk16(rv, ey[15:0]);
		u_host.rd(7'h3A, rv);
		chk16(rv, ez[31:16]);
		u_host.rd(7'h38, rv);
		chk16(rv, ez[15:0]);
	endtask

	initial
	begin
		err_total = 0;
		n_checks = 0;
		reset = 1'b1;
		flashRestore = 1'b0;
		flashImage = 96'h0;
		decimationSetting = 16'h0000;
		{accelY, accelZ} = 32'h0;
		{factoryGyroX, factoryGyroY, factoryGyroZ} = 96'h0;
		repeat (3) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_reset();
		t_rate();
		t_flash();
		t_dvel(16'h0000, 16'h0100, 16'hFFFD);
		t_dvel(16'h0003, 16'h7FFF, 16'h8000);
		conclude();
	end
endmodule // imu_dvel_out_gyro_bias_regs_tb

bind imu_dvel_out_gyro_bias_regs imu_bank_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (.ref_clk, .reset,
	.regWrEn, .regRdEn, .regRdData_ff, .regRdValid_ff, .flashRestore, .biasImage, .factoryGyroX, .sampleTick_ff,
	.gyroX_ff, .gyroValid_ff, .dvelUpdate_ff);
